/* File: src/qup_pkg.sv */
// Purpose: constants for the quad uart host bus port
// Assumes: one clock, synchronous active-high srst
// Notes:   register file is a stand-in for channel registers
package qup_pkg;
	localparam int NUM_CHAN       = 4;
	localparam int DATA_W         = 8;
	localparam int ADDR_W         = 5;
	localparam int REG_AW         = 3;
	localparam int CHAN_AW        = 2;
	localparam int MCR_OFFSET     = 4;
	localparam int IER_OFFSET     = 1;
	localparam int MCR_IRQ_EN_BIT = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
endpackage : qup_pkg

/* File: src/qup_reg_mem.sv */
// Purpose: per-channel register storage, registered read
// Assumes: one write port, one read port
// Notes:   clear on reset
`timescale 1ns/1ps
`default_nettype none
module qup_reg_mem #(
	parameter int DEPTH = 32,
	parameter int AW    = 5,
	parameter int DW    = 8
) (
	input  wire logic          clk_sys,
	input  wire logic          srst,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output var  logic [DW-1:0] rd_data,
	output var  logic [DEPTH*DW-1:0] all_data
);
	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] next_mem [DEPTH];
	logic [DW-1:0] next_rd_data;

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_mem[i] = mem[i];
			all_data[i*DW +: DW] = mem[i];
		end
		if (wr_en) begin
			next_mem[wr_addr] = wr_data;
		end
		next_rd_data = mem[rd_addr];
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] <= srst ? qup_pkg::REG_RESET : next_mem[i];
		end
		rd_data <= srst ? qup_pkg::REG_RESET : next_rd_data;
	end
endmodule : qup_reg_mem
`default_nettype wire

/* File: src/qup_host_port.sv */
// Purpose: host-side parallel bus port of a four-channel uart
// Assumes: bus pins sampled synchronously to clk_sys
// Notes:   mode_sep high selects separate strobes
`timescale 1ns/1ps
`default_nettype none
module qup_host_port #(
	parameter int NCH = qup_pkg::NUM_CHAN
) (
	input  wire logic           clk_sys,
	input  wire logic           srst,
	input  wire logic           mode_sep,
	input  wire logic           reset_pin,
	input  wire logic           irq_output_gate_select,
	input  wire logic [NCH-1:0] chan_sel_n,
	input  wire logic           comb_sel_n,
	input  wire logic [4:0]     addr,
	input  wire logic           read_strobe_n,
	input  wire logic           write_strobe_n,
	input  wire logic [7:0]     data_in,
	input  wire logic [NCH-1:0] irq_condition,
	input  wire logic [NCH-1:0] rx_has_data,
	input  wire logic [NCH-1:0] tx_has_space,
	output logic      [7:0]     data_out,
	output logic                data_oe,
	output logic      [NCH-1:0] chan_irq,
	output logic      [NCH-1:0] chan_irq_oe,
	output logic                req_pin_out,
	output logic                req_pin_oe,
	output logic                any_rx_ready_n,
	output logic                any_tx_ready_n,
	output logic                uart_reset
);
	// ----------------------------------------
	// reset and strobe edges
	// ----------------------------------------
	logic       rd_q;
	logic       wr_q;
	logic       next_rd_q;
	logic       next_wr_q;
	logic       dev_rst;
	logic       sep_rd;
	logic       sep_wr;
	logic       cmb_rd;
	logic       cmb_wr;
	logic       any_sel;
	logic [1:0] sep_chan;
	logic [1:0] wchan;
	logic [2:0] wreg;
	logic       wr_en;

	function automatic logic [1:0] onehot_idx(input logic [NCH-1:0] sel_n);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = 0; i < NCH; i++) begin
			if (!sel_n[i]) begin
				idx = 2'(i);
			end
		end
		return idx;
	endfunction : onehot_idx

	always_comb begin
		// separate style high resets; combined style low resets
		dev_rst   = srst | (mode_sep ? reset_pin : ~reset_pin);
		next_rd_q = read_strobe_n;
		next_wr_q = write_strobe_n;
		any_sel   = ~&chan_sel_n;
		sep_chan  = onehot_idx(chan_sel_n);
		sep_rd    = mode_sep & rd_q & ~read_strobe_n & any_sel;
		sep_wr    = mode_sep & wr_q & ~write_strobe_n & any_sel;
		// write_strobe_n serves as the combined read/write strobe
		cmb_wr    = ~mode_sep & wr_q & ~write_strobe_n & ~comb_sel_n;
		cmb_rd    = ~mode_sep & ~wr_q & write_strobe_n & ~comb_sel_n;
		wchan     = mode_sep ? sep_chan : addr[4:3];
		wreg      = addr[2:0];
		wr_en     = sep_wr | cmb_wr;
	end

	always_ff @(posedge clk_sys) begin
		rd_q <= srst ? 1'h1 : next_rd_q;
		wr_q <= srst ? 1'h1 : next_wr_q;
	end

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0]   rd_data;
	logic [255:0] all_regs;

	qup_reg_mem #(
		.DEPTH (32),
		.AW    (5),
		.DW    (8)
	) u_mem (
		.clk_sys  (clk_sys),
		.srst     (dev_rst),
		.wr_en    (wr_en),
		.wr_addr  ({wchan, wreg}),
		.wr_data  (data_in),
		.rd_addr  ({wchan, wreg}),
		.rd_data  (rd_data),
		.all_data (all_regs)
	);

	// ----------------------------------------
	// data bus drive
	// ----------------------------------------
	logic rd_pend;
	logic next_rd_pend;
	logic next_data_oe;

	always_comb begin
		next_rd_pend = (sep_rd | cmb_rd) & ~dev_rst;
		if (mode_sep) begin
			next_data_oe = ~read_strobe_n & any_sel & ~dev_rst;
		end else begin
			next_data_oe = write_strobe_n & ~comb_sel_n & ~dev_rst;
		end
	end

	always_ff @(posedge clk_sys) begin
		rd_pend  <= dev_rst ? 1'h0 : next_rd_pend;
		data_oe  <= next_data_oe;
		data_out <= dev_rst ? 8'h00 : (rd_pend ? rd_data : data_out);
	end

	// ----------------------------------------
	// interrupts and ready outputs
	// ----------------------------------------
	logic [NCH-1:0] ch_active;
	logic [NCH-1:0] next_irq;
	logic [NCH-1:0] next_irq_oe;
	logic           next_req_out;
	logic           next_req_oe;
	logic           next_rx_n;
	logic           next_tx_n;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ch_active[i] = irq_condition[i]
				& (|all_regs[(i*8+qup_pkg::IER_OFFSET)*8 +: 8])
				& all_regs[(i*8+qup_pkg::MCR_OFFSET)*8 + qup_pkg::MCR_IRQ_EN_BIT];
			next_irq[i]    = mode_sep & ch_active[i];
			next_irq_oe[i] = mode_sep & (irq_output_gate_select
				| all_regs[(i*8+qup_pkg::MCR_OFFSET)*8 + qup_pkg::MCR_IRQ_EN_BIT]);
		end
		if (mode_sep) begin
			next_req_out = ch_active[0];
			next_req_oe  = next_irq_oe[0];
		end else begin
			next_req_out = 1'h0;
			next_req_oe  = |ch_active;
		end
		next_rx_n = ~|rx_has_data;
		next_tx_n = ~|tx_has_space;
		if (dev_rst) begin
			next_irq     = '0;
			next_irq_oe  = '0;
			next_req_out = 1'h0;
			next_req_oe  = 1'h0;
			next_rx_n    = 1'h1;
			next_tx_n    = 1'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		chan_irq       <= next_irq;
		chan_irq_oe    <= next_irq_oe;
		req_pin_out    <= next_req_out;
		req_pin_oe     <= next_req_oe;
		any_rx_ready_n <= next_rx_n;
		any_tx_ready_n <= next_tx_n;
		uart_reset     <= dev_rst;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_rx_ready_or: assert property (@(posedge clk_sys) disable iff (dev_rst)
		(|rx_has_data) |=> any_rx_ready_n == 1'h0 || $past(dev_rst))
		else $error("rx ready not low");
	chk_tx_ready_full: assert property (@(posedge clk_sys) disable iff (dev_rst)
		(tx_has_space == '0) |=> any_tx_ready_n || $past(dev_rst))
		else $error("tx ready not high when full");
	chk_req_no_high: assert property (@(posedge clk_sys) disable iff (srst)
		!mode_sep |=> !(req_pin_oe && req_pin_out) || $past(mode_sep))
		else $error("request driven high");
	chk_sel_ignored: assert property (@(posedge clk_sys) disable iff (srst)
		!mode_sep |=> chan_irq_oe == '0 || $past(mode_sep))
		else $error("irq oe in combined style");
	chk_gate_force: assert property (@(posedge clk_sys) disable iff (dev_rst)
		(mode_sep && irq_output_gate_select) |=> chan_irq_oe == '1 || $past(dev_rst))
		else $error("irq not forced on");
	chk_sep_reset: assert property (@(posedge clk_sys) disable iff (srst)
		(mode_sep && reset_pin) |=> uart_reset && any_rx_ready_n)
		else $error("high reset ignored");
	chk_cmb_reset: assert property (@(posedge clk_sys) disable iff (srst)
		(!mode_sep && !reset_pin) |=> uart_reset && chan_irq == '0)
		else $error("low reset ignored");
	chk_read_drive: assert property (@(posedge clk_sys) disable iff (dev_rst)
		sep_rd |=> data_oe || $past(dev_rst))
		else $error("read not driven");
	chk_irq_a_pin: assert property (@(posedge clk_sys) disable iff (dev_rst)
		mode_sep |=> req_pin_out == chan_irq[0] || $past(dev_rst) || !$past(mode_sep))
		else $error("pin not channel a");
endmodule : qup_host_port
`default_nettype wire

/* File: testbench/qup_cpu_model.sv */
// Purpose: cpu side of the host bus, pull-up on request line
// Assumes: one clock
// Notes:   released data bus shows inverse of last driven value
`timescale 1ns/1ps
`default_nettype none
module qup_cpu_model (
	input  wire logic       clk_sys,
	input  wire logic       req_pin_out,
	input  wire logic       req_pin_oe,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic            req_wire,
	output logic      [7:0] data_bus
);
	logic [7:0] last = 8'h00;
	always_ff @(posedge clk_sys) if (data_oe) last <= data_out;
	assign req_wire = req_pin_oe ? req_pin_out : 1'b1;
	assign data_bus = data_oe ? data_out : ~last;
endmodule : qup_cpu_model
`default_nettype wire

/* File: testbench/quad_uart_host_bus_port_tb_top.sv */
// Purpose: directed bench for the host bus port
// Assumes: inputs driven by nba at rising edge
// Notes:   fixed waits follow the hand-over latencies
`timescale 1ns/1ps
`default_nettype none
module quad_uart_host_bus_port_tb_top;
	logic clk_sys = 1'b0, srst = 1'b1, mode_sep = 1'b1, reset_pin = 1'b0;
	logic irq_output_gate_select = 1'b0, comb_sel_n = 1'b1;
	logic read_strobe_n = 1'b1, write_strobe_n = 1'b1;
	logic [3:0] chan_sel_n = 4'hf, irq_condition = 4'h0, rx_has_data = 4'h0, tx_has_space = 4'h0;
	logic [4:0] addr = 5'h00;
	logic [7:0] data_in = 8'h00, data_out, data_bus;
	logic [3:0] chan_irq, chan_irq_oe;
	logic data_oe, req_pin_out, req_pin_oe, any_rx_ready_n, any_tx_ready_n, uart_reset, req_wire;
	int err_count = 0, total_checks = 0;
	always #2 clk_sys = ~clk_sys;
	qup_host_port dut (.clk_sys, .srst, .mode_sep, .reset_pin, .irq_output_gate_select,
		.chan_sel_n, .comb_sel_n, .addr, .read_strobe_n, .write_strobe_n, .data_in,
		.irq_condition, .rx_has_data, .tx_has_space, .data_out, .data_oe, .chan_irq,
		.chan_irq_oe, .req_pin_out, .req_pin_oe, .any_rx_ready_n, .any_tx_ready_n, .uart_reset);
	qup_cpu_model cpu (.clk_sys, .req_pin_out, .req_pin_oe, .data_out, .data_oe, .req_wire,
		.data_bus);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic sep_acc(input int ch, input logic [2:0] a, input logic [7:0] d, input bit rd);
		@(posedge clk_sys);
		chan_sel_n <= ~(4'h1 << ch);
		addr <= {2'b00, a};
		data_in <= d;
		if (rd) read_strobe_n <= 1'b0;
		else write_strobe_n <= 1'b0;
		wt(4);
		if (rd) chk("sep data", data_bus, d);
		if (rd) chk("sep oe", {7'h00, data_oe}, 8'h01);
		@(posedge clk_sys);
		read_strobe_n <= 1'b1;
		write_strobe_n <= 1'b1;
		chan_sel_n <= 4'hf;
		wt(2);
	endtask : sep_acc
	task automatic comb_acc(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		comb_sel_n <= 1'b0;
		addr <= a;
		data_in <= d;
		write_strobe_n <= 1'b0;
		wt(3);
		@(posedge clk_sys);
		data_in <= ~d;
		write_strobe_n <= 1'b1;
		wt(4);
		chk("comb data", data_bus, d);
		chk("comb oe", {7'h00, data_oe}, 8'h01);
		@(posedge clk_sys);
		comb_sel_n <= 1'b1;
		wt(2);
	endtask : comb_acc
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_sep;
		sep_acc(1, 3'd7, 8'h5a, 1'b0);
		sep_acc(2, 3'd7, 8'hc3, 1'b0);
		sep_acc(1, 3'd7, 8'h5a, 1'b1);
		sep_acc(0, 3'd1, 8'h01, 1'b0);
		sep_acc(0, 3'd4, 8'h08, 1'b0);
		@(posedge clk_sys);
		irq_condition <= 4'h1;
		wt(3);
		chk("irq", {4'h0, chan_irq}, 8'h01);
		chk("irq oe", {4'h0, chan_irq_oe}, 8'h01);
		chk("pin a", {7'h00, req_pin_out}, 8'h01);
		@(posedge clk_sys);
		irq_output_gate_select <= 1'b1;
		irq_condition <= 4'h0;
		wt(3);
		chk("irq forced oe", {4'h0, chan_irq_oe}, 8'h0f);
		chk("irq gone", {4'h0, chan_irq}, 8'h00);
		$display("done sep");
	endtask : t_sep
	task automatic t_ready;
		@(posedge clk_sys);
		rx_has_data <= 4'h8;
		wt(3);
		chk("rx rdy", {7'h00, any_rx_ready_n}, 8'h00);
		chk("tx full", {7'h00, any_tx_ready_n}, 8'h01);
		@(posedge clk_sys);
		rx_has_data <= 4'h0;
		tx_has_space <= 4'h4;
		wt(3);
		chk("rx none", {7'h00, any_rx_ready_n}, 8'h01);
		chk("tx rdy", {7'h00, any_tx_ready_n}, 8'h00);
		$display("done ready");
	endtask : t_ready
	task automatic t_reset_sep;
		@(posedge clk_sys);
		reset_pin <= 1'b1;
		wt(3);
		chk("reset hi", {7'h00, uart_reset}, 8'h01);
		chk("reset oe", {4'h0, chan_irq_oe}, 8'h00);
		chk("reset tx", {7'h00, any_tx_ready_n}, 8'h01);
		@(posedge clk_sys);
		reset_pin <= 1'b0;
		wt(2);
		sep_acc(1, 3'd7, 8'h00, 1'b1);
		$display("done reset");
	endtask : t_reset_sep
	task automatic t_comb;
		@(posedge clk_sys);
		mode_sep <= 1'b0;
		reset_pin <= 1'b1;
		irq_condition <= 4'h2;
		wt(3);
		chk("comb no reset", {7'h00, uart_reset}, 8'h00);
		chk("gate ignored", {7'h00, req_pin_oe}, 8'h00);
		chk("gate ignored oe", {4'h0, chan_irq_oe}, 8'h00);
		comb_acc({2'd2, 3'd1}, 8'h01);
		comb_acc({2'd2, 3'd4}, 8'h08);
		@(posedge clk_sys);
		irq_condition <= 4'h4;
		wt(3);
		chk("merged req", {7'h00, req_wire}, 8'h00);
		chk("never high", {7'h00, req_pin_out}, 8'h00);
		@(posedge clk_sys);
		irq_condition <= 4'h0;
		reset_pin <= 1'b0;
		wt(3);
		chk("req released", {7'h00, req_wire}, 8'h01);
		chk("comb reset", {7'h00, uart_reset}, 8'h01);
		$display("done comb");
	endtask : t_comb
	initial begin
		#100000;
		err_count++;
		conclude();
	end
	initial begin
		wt(3);
		@(posedge clk_sys);
		srst <= 1'b0;
		wt(1);
		t_sep();
		t_ready();
		t_reset_sep();
		t_comb();
		conclude();
	end
endmodule : quad_uart_host_bus_port_tb_top
`default_nettype wire
